// *** rtl/privilege_check_reset_state.v ***
// Privilege checks, coprocessor traps and reset state of the processor core
`timescale 1ns/1ns
`include "priv_check_map.vh"

// Operation
// - Privileged op above level zero faults 13
// - Table load, status load, clear, halt privileged
// - Emulation traps coprocessor opcodes, never wait
// - Monitor traps opcode and wait when switched
// - All three bits clear: no trap
// - Flag restore changes interrupt enable only trusted
// - I/O limit field changes only at zero
// - Port, string, enable ops and lock trusted
// - No execution or bus while reset
// - Start real mode four to five clocks later
// - Flags 0002, status FFF0, pointer FFF0
// - Code segment F000, base FF0000, limit FFFF
// - Data, extra, stack segments zero, limit FFFF
// - Interrupt table base zero, limit 03FF
// - First fetch at FFFFF0
// - Real mode, interrupts off, coprocessor bits clear
// - Real mode code reload clears upper base
// - Write back accessed and busy descriptor bits
// - Status bit layout; protected bit sticks
// - Hardware sets task switched; clear op clears
module privilege_check_reset_state (
    input wire SYS_CLK,
    input wire NRST,
    input wire INSTR_VALID,
    input wire [3:0] INSTR_CLASS,
    input wire [1:0] CURRENT_PRIVILEGE_LEVEL,
    input wire [15:0] OPERAND,
    input wire [23:0] OPERAND_BASE,
    input wire [15:0] OPERAND_LIMIT,
    input wire TASK_SWITCH_EVENT,
    input wire DESC_IS_TASK,
    input wire [23:0] DESC_ADDR,
    output reg RUNNING,
    output reg EXEC_DONE,
    output reg FAULT,
    output reg [7:0] FAULT_VECTOR,
    output reg [15:0] FAULT_CODE,
    output reg HALTED,
    output reg [15:0] FLAGS,
    output reg [15:0] MACHINE_STATUS_WORD,
    output reg [15:0] INSTRUCTION_POINTER,
    output reg [15:0] CODE_SEL,
    output reg [23:0] CODE_BASE,
    output reg [15:0] CODE_LIMIT,
    output reg [15:0] DATA_SEL,
    output reg [23:0] DATA_BASE,
    output reg [15:0] DATA_LIMIT,
    output reg [15:0] EXTRA_SEL,
    output reg [23:0] EXTRA_BASE,
    output reg [15:0] EXTRA_LIMIT,
    output reg [15:0] STACK_SEL,
    output reg [23:0] STACK_BASE,
    output reg [15:0] STACK_LIMIT,
    output reg [23:0] IDT_BASE,
    output reg [15:0] IDT_LIMIT,
    output reg FETCH_VALID,
    output reg [23:0] FETCH_ADDR,
    output reg DESC_WB_VALID,
    output reg [23:0] DESC_WB_ADDR,
    output reg [7:0] DESC_WB_SET_BITS
);

    // ----------------------------------------
    // Reset settle and decision logic
    // ----------------------------------------

    // Outputs of the two helper modules
    wire run; // Execution allowed
    wire fault_now; // Current instruction faults
    wire [7:0] vector_now; // Vector for that fault
    wire trusted; // Level trusted against I/O limit

    // Settle interval after reset release
    // Requests before the interval ends get no answer at all
    // The counter restarts on every reset
    reset_settle u_settle (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .run(run)
    );

    // Exception decision for the presented instruction
    // Pure decode of class, level, limit field and status bits
    // The registered side below turns it into a one-cycle answer
    // Real mode makes every level count as zero in the decoder
    priv_decide u_decide (
        .cls(INSTR_CLASS),
        .current_privilege_level(CURRENT_PRIVILEGE_LEVEL),
        .io_privilege_limit(FLAGS[`FLG_IO_PRIVILEGE_LIMIT_HI:`FLG_IO_PRIVILEGE_LIMIT_LO]),
        .msw_low(MACHINE_STATUS_WORD[3:0]),
        .fault(fault_now),
        .vector(vector_now),
        .trusted(trusted)
    );

    // ----------------------------------------
    // Derived terms
    // ----------------------------------------

    // Protected enable gates every level check
    wire protected_enable = MACHINE_STATUS_WORD[`MSW_PE_BIT];
    // Instruction accepted only while running and not halted
    wire take = INSTR_VALID && run && !HALTED;
    // Executed means taken and not suppressed
    wire do_exec = take && !fault_now;
    // Real mode counts as level zero here
    wire level_zero = !protected_enable || (CURRENT_PRIVILEGE_LEVEL == 2'h0);

    // Next values, built combinationally
    reg [15:0] next_flags; // Flag word after a restore
    reg [15:0] next_msw; // Status word after load or events
    reg [23:0] real_base; // Real mode code base from selector

    // Merge restored flags, keeping guarded fields where not allowed
    // Bit one of the flag word always reads as one
    // An untrusted restore keeps interrupt enable as it was
    // Only level zero may move the I/O limit field
    always @* begin
        next_flags = OPERAND;
        next_flags[`FLG_FIXED_BIT] = 1'b1;
        if (!trusted) begin
            next_flags[`FLG_IF_BIT] = FLAGS[`FLG_IF_BIT];
        end
        if (!level_zero) begin
            // Keep limit field
            next_flags[`FLG_IO_PRIVILEGE_LIMIT_HI:`FLG_IO_PRIVILEGE_LIMIT_LO] =
                FLAGS[`FLG_IO_PRIVILEGE_LIMIT_HI:`FLG_IO_PRIVILEGE_LIMIT_LO];
        end
    end

    // Status word update: load, clear op, hardware set
    // Later assignments override earlier ones, so the order
    // fixes priority: load, then clear, then the hardware set
    // A load may set the switched flag; the clear op removes it
    // Events before the settle interval ends are dropped
    always @* begin
        next_msw = MACHINE_STATUS_WORD;
        if (do_exec && INSTR_CLASS == `CLS_LOAD_MSW) begin
            next_msw = OPERAND;
            // Protected bit cannot be cleared by a load
            next_msw[`MSW_PE_BIT] = OPERAND[`MSW_PE_BIT] | protected_enable;
        end
        if (do_exec && INSTR_CLASS == `CLS_CLEAR_TS) begin
            next_msw[`MSW_TS_BIT] = 1'b0;
        end
        if (TASK_SWITCH_EVENT && run) begin
            // Hardware set wins over a same-cycle clear
            next_msw[`MSW_TS_BIT] = 1'b1;
        end
    end

    // Real mode code base: selector times sixteen, upper nibble zero
    // A real mode reload never reaches the top of memory again
    // Only reset or a protected mode code load brings the code base back up there
    always @* begin
        real_base = {4'h0, OPERAND, 4'h0};
    end

    // ----------------------------------------
    // Status outputs and fault reporting
    // ----------------------------------------

    // Run state, completion and fault pulses
    // Exactly one of done or fault follows a taken instruction
    // Both pulse one cycle; the vector holds until the next fault
    // The error code is always zero for these faults
    // Halt stops taking instructions until the next reset
    // Running drops one cycle after HALTED rises
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            RUNNING <= 1'b0;
            EXEC_DONE <= 1'b0;
            FAULT <= 1'b0;
            FAULT_VECTOR <= 8'h00;
            FAULT_CODE <= `ERR_CODE_ZERO;
            HALTED <= 1'b0;
        end else begin
            RUNNING <= run && !HALTED;
            EXEC_DONE <= do_exec;
            FAULT <= take && fault_now;
            // Vector and code captured only on a fault
            if (take && fault_now) begin
                FAULT_VECTOR <= vector_now;
                FAULT_CODE <= `ERR_CODE_ZERO;
            end
            // Halt latches until reset
            if (do_exec && INSTR_CLASS == `CLS_HALT) begin
                HALTED <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Flags and status word
    // ----------------------------------------

    // Flag word: reset value, restores and enable ops
    // Enable set and clear only arrive here when trusted,
    // since the decoder suppresses them otherwise
    // Suppressed instructions leave the word untouched
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            FLAGS <= `RST_FLAGS;
        end else if (do_exec) begin
            case (INSTR_CLASS)
                `CLS_POP_FLAGS, `CLS_INT_RETURN: begin
                    FLAGS <= next_flags;
                end
                `CLS_SET_IE: begin
                    FLAGS[`FLG_IF_BIT] <= 1'b1;
                end
                `CLS_CLEAR_IE: begin
                    FLAGS[`FLG_IF_BIT] <= 1'b0;
                end
                // Other classes keep the word
                default: begin
                    FLAGS <= FLAGS;
                end
            endcase
        end
    end

    // Status word register
    // Reset clears the low four bits: real mode, no coprocessor
    // Upper bits take the reset pattern or any loaded value
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            MACHINE_STATUS_WORD <= `RST_MSW;
        end else begin
            // Combined update from the merge above
            MACHINE_STATUS_WORD <= next_msw;
        end
    end

    // ----------------------------------------
    // Segment and table registers
    // ----------------------------------------

    // Code segment and instruction pointer
    // Reset points the first fetch at the top sixteen bytes
    // A code load restarts the pointer at zero
    // Protected mode takes the base supplied with the selector
    // Real mode derives the base from the selector alone
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            INSTRUCTION_POINTER <= `RST_IP;
            CODE_SEL <= `RST_CS_SEL;
            CODE_BASE <= `RST_CS_BASE;
            CODE_LIMIT <= `RST_SEG_LIMIT;
        end else if (do_exec && INSTR_CLASS == `CLS_CODE_LOAD) begin
            // New selector and limit
            CODE_SEL <= OPERAND;
            CODE_LIMIT <= OPERAND_LIMIT;
            INSTRUCTION_POINTER <= 16'h0000;
            if (protected_enable) begin
                CODE_BASE <= OPERAND_BASE;
            end else begin
                CODE_BASE <= real_base;
            end
        end
    end

    // Data, extra and stack segments hold their reset view
    // No load class reaches these registers, so they keep
    // selector zero, base zero and the full limit
    // The low sixty-four kilobytes stay reachable through them
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            DATA_SEL <= `RST_SEG_SEL;
            DATA_BASE <= `RST_SEG_BASE;
            DATA_LIMIT <= `RST_SEG_LIMIT;
            EXTRA_SEL <= `RST_SEG_SEL;
            EXTRA_BASE <= `RST_SEG_BASE;
            EXTRA_LIMIT <= `RST_SEG_LIMIT;
            STACK_SEL <= `RST_SEG_SEL;
            STACK_BASE <= `RST_SEG_BASE;
            STACK_LIMIT <= `RST_SEG_LIMIT;
        end else begin
            // Hold the reset view
            DATA_SEL <= DATA_SEL;
            STACK_SEL <= STACK_SEL;
        end
    end

    // Interrupt table register, loaded by the privileged op
    // Reset places the table at the bottom of memory
    // A load is only taken at level zero or in real mode
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            IDT_BASE <= `RST_IDT_BASE;
            IDT_LIMIT <= `RST_IDT_LIMIT;
        end else if (do_exec && INSTR_CLASS == `CLS_LOAD_IDT) begin
            // Base and limit arrive with the instruction
            IDT_BASE <= OPERAND_BASE;
            IDT_LIMIT <= OPERAND_LIMIT;
        end
    end

    // ----------------------------------------
    // Fetch request and descriptor write-back
    // ----------------------------------------

    // Fetch address from code base plus pointer, valid only while running
    // The address tracks the code registers one cycle late
    // During the settle interval it already shows the reset address
    // The valid flag stays low until running
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            FETCH_VALID <= 1'b0;
            FETCH_ADDR <= 24'h000000;
        end else begin
            // Valid follows run, dropped by halt
            FETCH_VALID <= run && !HALTED;
            FETCH_ADDR <= CODE_BASE + {8'h00, INSTRUCTION_POINTER};
        end
    end

    // Mark descriptors accessed, or busy for task state areas
    // One pulse per executed descriptor use, with its address
    // Tables therefore must sit in writable memory
    // Task state descriptors get busy, others accessed
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            DESC_WB_VALID <= 1'b0;
            DESC_WB_ADDR <= 24'h000000;
            DESC_WB_SET_BITS <= 8'h00;
        end else begin
            // Pulse for one cycle
            DESC_WB_VALID <= do_exec && INSTR_CLASS == `CLS_DESC_USE;
            if (do_exec && INSTR_CLASS == `CLS_DESC_USE) begin
                DESC_WB_ADDR <= DESC_ADDR;
                DESC_WB_SET_BITS <= DESC_IS_TASK ? `DESC_BUSY_MASK
                                                 : `DESC_ACCESSED_MASK;
            end
        end
    end

endmodule

// *** rtl/priv_check_map.vh ***
// Constants for the privilege check and reset state block
`ifndef PRIV_CHECK_MAP_VH
`define PRIV_CHECK_MAP_VH

// ----------------------------------------
// Instruction classes
// ----------------------------------------
`define CLS_OTHER 4'h0
`define CLS_LOAD_IDT 4'h1
`define CLS_LOAD_MSW 4'h2
`define CLS_CLEAR_TS 4'h3
`define CLS_HALT 4'h4
`define CLS_POP_FLAGS 4'h5
`define CLS_INT_RETURN 4'h6
`define CLS_PORT_IO 4'h7
`define CLS_SET_IE 4'h8
`define CLS_CLEAR_IE 4'h9
`define CLS_LOCK 4'ha
`define CLS_COPRO 4'hb
`define CLS_WAIT 4'hc
`define CLS_CODE_LOAD 4'hd
`define CLS_DESC_USE 4'he

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MSW_PE_BIT 0
`define MSW_MP_BIT 1
`define MSW_EM_BIT 2
`define MSW_TS_BIT 3
`define FLG_IF_BIT 9
`define FLG_IO_PRIVILEGE_LIMIT_LO 12
`define FLG_IO_PRIVILEGE_LIMIT_HI 13
`define FLG_FIXED_BIT 1

// ----------------------------------------
// Exception vectors and codes
// ----------------------------------------
`define VEC_GEN_PROT 8'h0d
`define VEC_COPRO_ABSENT 8'h07
`define ERR_CODE_ZERO 16'h0000

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FLAGS 16'h0002
`define RST_MSW 16'hfff0
`define RST_IP 16'hfff0
`define RST_CS_SEL 16'hf000
`define RST_CS_BASE 24'hff0000
`define RST_SEG_SEL 16'h0000
`define RST_SEG_BASE 24'h000000
`define RST_SEG_LIMIT 16'hffff
`define RST_IDT_BASE 24'h000000
`define RST_IDT_LIMIT 16'h03ff

// ----------------------------------------
// Descriptor write-back bits
// ----------------------------------------
`define DESC_ACCESSED_MASK 8'h01
`define DESC_BUSY_MASK 8'h02

// ----------------------------------------
// Timing after reset release
// ----------------------------------------
`define RESET_SETTLE_CLOCKS 3'h4

`endif

// *** rtl/reset_settle.v ***
// Waits the internal interval after reset release, then allows execution
`timescale 1ns/1ns
`include "priv_check_map.vh"

module reset_settle (
    input wire clk,
    input wire rst_n,
    output reg run
);

    reg [2:0] count; // Clocks since release

    // Count settle clocks, then hold run high until the next reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 3'h0;
            run <= 1'b0;
        end else if (!run) begin
            if (count == `RESET_SETTLE_CLOCKS - 3'h1) begin
                run <= 1'b1;
            end else begin
                count <= count + 3'h1;
            end
        end
    end

endmodule

// *** rtl/priv_decide.v ***
// Combinational decision: which exception, if any, an instruction raises
`timescale 1ns/1ns
`include "priv_check_map.vh"

module priv_decide (
    input wire [3:0] cls,
    input wire [1:0] current_privilege_level,
    input wire [1:0] io_privilege_limit,
    input wire [3:0] msw_low,
    output reg fault,
    output reg [7:0] vector,
    output wire trusted
);

    wire pe = msw_low[`MSW_PE_BIT];
    wire mp = msw_low[`MSW_MP_BIT];
    wire em = msw_low[`MSW_EM_BIT];
    wire ts = msw_low[`MSW_TS_BIT];
    // Real mode runs everything as level zero
    wire [1:0] eff_cpl = pe ? current_privilege_level : 2'h0;

    // Numerically at or below the I/O limit counts as trusted
    assign trusted = (eff_cpl <= io_privilege_limit);

    // Select the exception for this class
    always @* begin
        fault = 1'b0;
        vector = `VEC_GEN_PROT;
        case (cls)
            `CLS_LOAD_IDT, `CLS_LOAD_MSW, `CLS_CLEAR_TS, `CLS_HALT: begin
                fault = (eff_cpl != 2'h0);
            end
            `CLS_PORT_IO, `CLS_SET_IE, `CLS_CLEAR_IE, `CLS_LOCK: begin
                fault = !trusted;
            end
            `CLS_COPRO: begin
                // Emulation traps always; monitor traps only when switched
                if (em || (mp && ts)) begin
                    fault = 1'b1;
                    vector = `VEC_COPRO_ABSENT;
                end
            end
            `CLS_WAIT: begin
                // Wait never traps under emulation alone
                if (mp && ts) begin
                    fault = 1'b1;
                    vector = `VEC_COPRO_ABSENT;
                end
            end
            default: begin
                fault = 1'b0;
            end
        endcase
    end

endmodule

// *** verif/priv_checker_assertions.sv ***
// Checker of privilege, trap and start-up behaviour at the block ports
`timescale 1ns/1ns
module priv_checker (
    input wire SYS_CLK,
    input wire NRST,
    input wire INSTR_VALID,
    input wire [3:0] INSTR_CLASS,
    input wire [1:0] CURRENT_PRIVILEGE_LEVEL,
    input wire TASK_SWITCH_EVENT,
    input wire RUNNING,
    input wire EXEC_DONE,
    input wire FAULT,
    input wire [7:0] FAULT_VECTOR,
    input wire [15:0] FAULT_CODE,
    input wire HALTED,
    input wire [15:0] FLAGS,
    input wire [15:0] MACHINE_STATUS_WORD,
    input wire FETCH_VALID,
    input wire [23:0] FETCH_ADDR
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    reg [2:0] since; // Edges since reset release, saturating
    wire go = INSTR_VALID && RUNNING && !HALTED; // Instruction taken
    wire [3:0] c = INSTR_CLASS;
    wire [3:0] m = MACHINE_STATUS_WORD[3:0];
    // Count edges after release
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            since <= 3'h0;
        end else if (since != 3'h7) begin
            since <= since + 3'h1;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_start_delay: assert property (
        since < 3'h5 |-> !RUNNING && !FETCH_VALID && !EXEC_DONE && !FAULT)
        else $error("activity before start interval ended");
    a_first_fetch: assert property (
        since == 3'h5 |-> RUNNING && FETCH_ADDR == 24'hfffff0)
        else $error("first fetch wrong");
    a_priv_fault: assert property (
        go && c >= 4'h1 && c <= 4'h4 && m[0] && CURRENT_PRIVILEGE_LEVEL != 2'h0
        |=> FAULT && FAULT_VECTOR == 8'h0d && FAULT_CODE == 16'h0000)
        else $error("privileged op not refused");
    a_emu_copro: assert property (
        go && c == 4'hb && m[2] |=> FAULT && FAULT_VECTOR == 8'h07)
        else $error("emulated opcode not trapped");
    a_wait_free: assert property (
        go && c == 4'hc && !m[1] |=> EXEC_DONE && !FAULT)
        else $error("wait trapped without monitor");
    a_monitor_wait: assert property (
        go && c == 4'hc && m[1] && m[3] |=> FAULT && FAULT_VECTOR == 8'h07)
        else $error("monitored wait not trapped");
    a_io_untrusted: assert property (
        go && c >= 4'h7 && c <= 4'ha && m[0] && CURRENT_PRIVILEGE_LEVEL > FLAGS[13:12]
        |=> FAULT && FAULT_VECTOR == 8'h0d && FAULT_CODE == 16'h0000)
        else $error("untrusted op not refused");
    a_io_privilege_limit_kept: assert property (
        go && (c == 4'h5 || c == 4'h6) && m[0] && CURRENT_PRIVILEGE_LEVEL != 2'h0
        |=> FLAGS[13:12] == $past(FLAGS[13:12]))
        else $error("limit field changed above level zero");
    a_pe_sticky: assert property (m[0] |=> m[0])
        else $error("protected enable cleared");
    a_ts_set: assert property (TASK_SWITCH_EVENT && RUNNING |=> m[3])
        else $error("switched flag not set");
    c_priv_fault: cover property (go && c == 4'h4 && m[0] && CURRENT_PRIVILEGE_LEVEL != 2'h0);
    c_copro_trap: cover property (FAULT && FAULT_VECTOR == 8'h07);
    c_halt: cover property (HALTED);
endmodule

bind privilege_check_reset_state priv_checker u_chk (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .INSTR_VALID(INSTR_VALID),
    .INSTR_CLASS(INSTR_CLASS), .CURRENT_PRIVILEGE_LEVEL(CURRENT_PRIVILEGE_LEVEL), .TASK_SWITCH_EVENT(TASK_SWITCH_EVENT),
    .RUNNING(RUNNING), .EXEC_DONE(EXEC_DONE), .FAULT(FAULT),
    .FAULT_VECTOR(FAULT_VECTOR), .FAULT_CODE(FAULT_CODE), .HALTED(HALTED),
    .FLAGS(FLAGS), .MACHINE_STATUS_WORD(MACHINE_STATUS_WORD),
    .FETCH_VALID(FETCH_VALID), .FETCH_ADDR(FETCH_ADDR)
);

// *** verif/privilege_check_reset_state_tb.sv ***
// Self-checking bench of privilege checks, traps and reset state
`timescale 1ns/1ns
module privilege_check_reset_state_tb;
    reg clk = 1'b0;
    reg nrst_n = 1'b0;
    reg valid = 1'b0;
    reg [3:0] cls = 4'h0;
    reg [1:0] current_privilege_level = 2'h0;
    reg [15:0] opd = 16'h0000;
    reg [23:0] obase = 24'h000000;
    reg [15:0] olim = 16'h0000;
    reg ts_ev = 1'b0;
    reg is_task = 1'b0;
    reg [23:0] daddr = 24'h000105;
    reg got_done, got_fault, got_wb; // Answer to the last instruction
    wire run, done, fault, halted, fv, wbv;
    wire [7:0] fvec, wbbits;
    wire [15:0] fcode, flags, machine_status_word, ip, csel, clim, dsel, dlim, esel, elim, ssel, slim, ilim;
    wire [23:0] cbase, dbase, ebase, sbase, ibase, faddr, wbaddr;
    integer mismatches = 0;
    integer checks = 0;
    integer i;
    always #20 clk = ~clk;
    privilege_check_reset_state dut (
        .SYS_CLK(clk), .NRST(nrst_n), .INSTR_VALID(valid), .INSTR_CLASS(cls), .CURRENT_PRIVILEGE_LEVEL(current_privilege_level),
        .OPERAND(opd), .OPERAND_BASE(obase), .OPERAND_LIMIT(olim),
        .TASK_SWITCH_EVENT(ts_ev), .DESC_IS_TASK(is_task), .DESC_ADDR(daddr),
        .RUNNING(run), .EXEC_DONE(done), .FAULT(fault), .FAULT_VECTOR(fvec),
        .FAULT_CODE(fcode), .HALTED(halted), .FLAGS(flags), .MACHINE_STATUS_WORD(machine_status_word),
        .INSTRUCTION_POINTER(ip), .CODE_SEL(csel), .CODE_BASE(cbase), .CODE_LIMIT(clim),
        .DATA_SEL(dsel), .DATA_BASE(dbase), .DATA_LIMIT(dlim), .EXTRA_SEL(esel),
        .EXTRA_BASE(ebase), .EXTRA_LIMIT(elim), .STACK_SEL(ssel), .STACK_BASE(sbase),
        .STACK_LIMIT(slim), .IDT_BASE(ibase), .IDT_LIMIT(ilim), .FETCH_VALID(fv),
        .FETCH_ADDR(faddr), .DESC_WB_VALID(wbv), .DESC_WB_ADDR(wbaddr),
        .DESC_WB_SET_BITS(wbbits)
    );
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input [127:0] seen, input [127:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (mismatches == 0 && checks > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    // One instruction for one edge, then one idle edge before the next
    task issue(input [3:0] k, input [1:0] p, input [15:0] v);
        begin
            valid = 1'b1;
            cls = k;
            current_privilege_level = p;
            opd = v;
            @(negedge clk);
            valid = 1'b0;
            got_done = done;
            got_fault = fault;
            got_wb = wbv;
            @(negedge clk);
        end
    endtask
    // Exactly one answer, with vector and zero code on a fault
    task answer(input f, input [7:0] vec);
        begin
            check({got_fault, got_done}, {f, !f});
            if (f) check({fvec, fcode}, {vec, 16'h0000});
        end
    endtask
    task pulse_ts;
        begin
            ts_ev = 1'b1;
            @(negedge clk);
            ts_ev = 1'b0;
            @(negedge clk);
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        begin
            valid = 1'b1; // Halt offered while reset holds
            cls = 4'h4;
            repeat (12) @(negedge clk);
            check({done, fault, run, fv, halted}, 5'h00);
            check({flags, machine_status_word, ip, csel}, 64'h0002_fff0_fff0_f000);
            check({cbase, clim}, 40'hff0000_ffff);
            check({dsel, esel, ssel, dbase, ebase, sbase}, 120'h0);
            check({dlim, elim, slim}, 48'hffff_ffff_ffff);
            check({ibase, ilim}, 40'h000000_03ff);
            check({flags[9], machine_status_word[2:0]}, 4'h0);
            valid = 1'b0;
            nrst_n = 1'b1;
            i = 0;
            while (!run && i < 20) begin
                @(posedge clk);
                i = i + 1;
                #1;
            end
            check(i, 5);
            check({fv, faddr}, {1'b1, 24'hfffff0});
            if (i >= 20) tally_and_finish;
            @(negedge clk);
        end
    endtask
    task t_real;
        begin
            issue(4'h9, 2'h3, 16'h0000);
            answer(1'b0, 8'h00);
            issue(4'hb, 2'h3, 16'h0000);
            answer(1'b0, 8'h00);
            issue(4'hc, 2'h3, 16'h0000);
            answer(1'b0, 8'h00);
            issue(4'h5, 2'h3, 16'h3200);
            check(flags, 16'h3202);
            issue(4'hd, 2'h0, 16'h1234);
            check({csel, cbase, ip, faddr}, 80'h1234_012340_0000_012340);
            for (i = 0; i < 2; i = i + 1) begin
                is_task = (i == 1);
                issue(4'he, 2'h0, 16'h0000);
                check({got_wb, wbaddr, wbbits}, {1'b1, 24'h000105, 8'h01 << i});
            end
        end
    endtask
    task t_prot;
        begin
            issue(4'h2, 2'h0, 16'h0001);
            issue(4'h0, 2'h0, 16'h0000);
            answer(1'b0, 8'h00);
            issue(4'h2, 2'h0, 16'h0000);
            check(machine_status_word[0], 1'b1);
            for (i = 1; i < 5; i = i + 1) begin
                issue(i[3:0], 2'h3, 16'h0000);
                answer(1'b1, 8'h0d);
            end
            check({ibase, ilim, machine_status_word[3:0], halted}, {40'h000000_03ff, 5'h02});
            obase = 24'h123456;
            olim = 16'h0400;
            issue(4'h1, 2'h0, 16'h0000);
            check({ibase, ilim}, 40'h123456_0400);
            issue(4'h5, 2'h1, 16'h0000);
            check(flags, 16'h3002);
            issue(4'h5, 2'h0, 16'h1200);
            check(flags, 16'h1202);
            issue(4'h6, 2'h2, 16'h0000);
            check(flags, 16'h1202);
            issue(4'h5, 2'h1, 16'h0000);
            check(flags, 16'h1002);
            for (i = 7; i < 11; i = i + 1) begin
                issue(i[3:0], 2'h2, 16'h0000);
                answer(1'b1, 8'h0d);
                issue(i[3:0], 2'h1, 16'h0000);
                answer(1'b0, 8'h00);
            end
            check(flags[9], 1'b0);
        end
    endtask
    task t_copro;
        begin
            issue(4'h2, 2'h0, 16'h0005);
            issue(4'hb, 2'h1, 16'h0000);
            answer(1'b1, 8'h07);
            pulse_ts;
            check(machine_status_word[3], 1'b1);
            issue(4'hb, 2'h1, 16'h0000);
            answer(1'b1, 8'h07);
            issue(4'hc, 2'h1, 16'h0000);
            answer(1'b0, 8'h00);
            issue(4'h3, 2'h0, 16'h0000);
            check(machine_status_word[3], 1'b0);
            issue(4'h2, 2'h0, 16'h0003);
            issue(4'hb, 2'h1, 16'h0000);
            answer(1'b0, 8'h00);
            issue(4'hc, 2'h1, 16'h0000);
            answer(1'b0, 8'h00);
            pulse_ts;
            issue(4'hb, 2'h1, 16'h0000);
            answer(1'b1, 8'h07);
            issue(4'hc, 2'h1, 16'h0000);
            answer(1'b1, 8'h07);
            issue(4'h4, 2'h0, 16'h0000);
            answer(1'b0, 8'h00);
            check(halted, 1'b1);
            issue(4'h9, 2'h0, 16'h0000);
            check({got_done, got_fault}, 2'h0);
        end
    endtask
    initial begin
        t_reset;
        t_real;
        t_prot;
        t_copro;
        tally_and_finish;
    end
endmodule
